// ---- hdl/lockdown_pkg.sv ----
// Constants shared by the sector protection and lockdown logic.
package lockdown_pkg;

    // ----------------------------------------------------------------
    // Command opcodes and fixed command bytes
    // ----------------------------------------------------------------
    localparam logic [7:0]  OP_WRITE_ENABLE   = 8'h06;
    localparam logic [7:0]  OP_WRITE_DISABLE  = 8'h04;
    localparam logic [7:0]  OP_WRITE_STATUS1  = 8'h01;
    localparam logic [7:0]  OP_WRITE_STATUS2  = 8'h31;
    localparam logic [7:0]  OP_PROTECT_SECT   = 8'h36;
    localparam logic [7:0]  OP_UNPROTECT_SECT = 8'h39;
    localparam logic [7:0]  OP_SECT_LOCKDOWN  = 8'h33;
    localparam logic [7:0]  OP_FREEZE_LOCK    = 8'h34;
    localparam logic [7:0]  CONFIRM_BYTE      = 8'hd0;
    localparam logic [23:0] FREEZE_ADDR       = 24'h55aa40;

    // ----------------------------------------------------------------
    // Status byte fields
    // ----------------------------------------------------------------
    localparam int          LOCK_BIT_POS      = 7;
    localparam int          GLOBAL_LSB        = 2;
    localparam int          GLOBAL_W          = 4;
    localparam logic [3:0]  GLOBAL_UNPROTECT  = 4'h0;
    localparam logic [3:0]  GLOBAL_PROTECT    = 4'hf;
    localparam int          LOCKEN_BIT_POS    = 4;

    // ----------------------------------------------------------------
    // Frame byte positions and counts
    // ----------------------------------------------------------------
    localparam logic [2:0]  BYTE_OPCODE       = 3'h0;
    localparam logic [2:0]  BYTE_ADDR_HI      = 3'h1;
    localparam logic [2:0]  BYTE_ADDR_MID     = 3'h2;
    localparam logic [2:0]  BYTE_ADDR_LO      = 3'h3;
    localparam logic [2:0]  BYTE_CONFIRM      = 3'h4;
    localparam logic [2:0]  NBYTES_OPCODE     = 3'h1;
    localparam logic [2:0]  NBYTES_STATUS     = 3'h2;
    localparam logic [2:0]  NBYTES_ADDR       = 3'h4;
    localparam logic [2:0]  NBYTES_CONFIRM    = 3'h5;
    localparam logic [2:0]  BIT_LAST          = 3'h7;

    // ----------------------------------------------------------------
    // Array geometry and timing
    // ----------------------------------------------------------------
    localparam int          NUM_SECTORS       = 64;
    localparam int          SECTOR_ADDR_LSB   = 16;
    localparam int          CLK_PERIOD_NS     = 20;
    localparam int          LOCK_TIME_NS      = 200000;
    localparam int          LOCK_CYCLES       = LOCK_TIME_NS / CLK_PERIOD_NS;

endpackage : lockdown_pkg

// ---- hdl/sector_lock_protection.sv ----
// Sector protection, locking and permanent lockdown control of a serial flash.
//
// Contract
// - Hardware lock is active only with write protect low and lock bit one.
// - Hardware lock ignores sector protect, unprotect and status byte one writes.
// - Clearing the lock bit performs no global protect or unprotect.
// - With write protect held low, a set lock bit clears only at power-up.
// - Power-up leaves every sector protected, lock bit zero.
// - With write protect high the lock bit may be set, software locking.
// - Setting the lock bit also applies the global code in bits five to two.
// - Software lock allows clearing the lock bit but ignores sector commands.
// - Either lock holds protection bits and blocks global protect/unprotect.
// - One lockdown bit per sector, default zero, survives reset; one blocks writes.
// - Successful lockdown sets the sector bit; only factory init clears it.
// - Lockdown is opcode, three address bytes, confirm byte; extra bytes ignored.
// - On valid lockdown, set bit within lock time and clear write enable.
// - Bad address, confirm or alignment aborts lockdown; only write enable clears.
// - Disabled or frozen lockdown is ignored; write enable cleared at frame end.
// - Freeze needs write enable, lockdown enable, fixed address and confirm.
// - Valid freeze freezes lockdown, clears write enable and lockdown enable forever.
// - After freeze every lockdown command is rejected.
// - Bad freeze aborts, clears write enable, keeps lockdown enable.
// - Status byte one stores only bit seven; bits five to two decode globals.
// - Unlocked, 00h unprotects all and 7Fh protects all, lock bit stays zero.
`timescale 1ns/100ps

module sector_lock_protection
#(
    parameter int NUM_SECTORS = lockdown_pkg::NUM_SECTORS,
    parameter int LOCK_CYCLES = lockdown_pkg::LOCK_CYCLES
)
(
    input  wire logic                   clk_i,           // System clock, 50 MHz.
    input  wire logic                   resetn_i,        // Power-on reset, active low.
    input  wire logic                   nv_init_n_i,     // Factory init of lockdown, low.
    input  wire logic                   sck_i,           // Serial clock pin.
    input  wire logic                   cs_n_i,          // Chip select pin, active low.
    input  wire logic                   si_i,            // Serial data in pin.
    input  wire logic                   wp_n_i,          // Write protect pin, active low.
    output logic                        write_enable_latch_o,       // Write enable latch.
    output logic                        protection_regs_lock_bit_o, // Lock bit.
    output logic                        lockdown_enable_bit_o,      // Lockdown enable.
    output logic                        hw_locked_o,     // Hardware lock active.
    output logic                        frozen_o,        // Lockdown state frozen.
    output logic                        busy_o,          // Lock operation running.
    output logic [NUM_SECTORS-1:0]      sect_protect_o,  // Sector protection bits.
    output logic [NUM_SECTORS-1:0]      sect_lockdown_o  // Lockdown bits; one blocks writes.
);

    localparam int SW = $clog2(NUM_SECTORS);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic                   write_enable_latch;
        logic                   protection_regs_lock_bit;
        logic                   lockdown_enable_bit;
        logic                   hw_locked;
        logic [7:0]             opcode;
        logic [7:0]             data1;
        logic [23:0]            addr;
        logic [7:0]             conf;
        logic [2:0]             nbytes;
        logic                   busy;
        logic [31:0]            timer;
        logic                   pend_freeze;
        logic [SW-1:0]          pend_sector;
        logic [NUM_SECTORS-1:0] prot;
    } vol_t;

    // Nonvolatile state lives on its own reset so a power cycle keeps it.
    typedef struct packed {
        logic                   frozen;
        logic [NUM_SECTORS-1:0] lockdown;
    } nv_t;

    vol_t vol_r;
    vol_t vol_nxt;
    nv_t  nv_r;
    nv_t  nv_nxt;

    // ----------------------------------------------------------------
    // Link sampling
    // ----------------------------------------------------------------
    logic       byte_vld;
    logic [7:0] byte_q;
    logic [2:0] byte_num;
    logic       frame_end;
    logic       aligned;
    logic       wp_n_s;

    spi_frame_rx u_rx
    (
        .clk_i       (clk_i),
        .resetn_i    (resetn_i),
        .sck_i       (sck_i),
        .cs_n_i      (cs_n_i),
        .si_i        (si_i),
        .wp_n_i      (wp_n_i),
        .byte_vld_o  (byte_vld),
        .byte_o      (byte_q),
        .byte_num_o  (byte_num),
        .frame_end_o (frame_end),
        .aligned_o   (aligned),
        .wp_n_o      (wp_n_s)
    );

    // ----------------------------------------------------------------
    // Decode helpers
    // ----------------------------------------------------------------
    logic          hw_lock;
    logic [SW-1:0] sector;
    logic [3:0]    global_code;
    logic          new_lock;

    assign hw_lock     = !wp_n_s && vol_r.protection_regs_lock_bit;
    assign sector      = vol_r.addr[lockdown_pkg::SECTOR_ADDR_LSB +: SW];
    assign global_code = vol_r.data1[lockdown_pkg::GLOBAL_LSB +: lockdown_pkg::GLOBAL_W];
    assign new_lock    = vol_r.data1[lockdown_pkg::LOCK_BIT_POS];

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb
    begin
        vol_nxt           = vol_r;
        nv_nxt            = nv_r;
        vol_nxt.hw_locked = hw_lock;

        // Collect the bytes of the current frame; bytes past the confirm are dropped.
        if (byte_vld)
        begin
            case (byte_num)
                lockdown_pkg::BYTE_OPCODE:
                    vol_nxt.opcode = byte_q;
                lockdown_pkg::BYTE_ADDR_HI:
                begin
                    vol_nxt.data1        = byte_q;
                    vol_nxt.addr[23:16]  = byte_q;
                end
                lockdown_pkg::BYTE_ADDR_MID:
                    vol_nxt.addr[15:8]   = byte_q;
                lockdown_pkg::BYTE_ADDR_LO:
                    vol_nxt.addr[7:0]    = byte_q;
                lockdown_pkg::BYTE_CONFIRM:
                    vol_nxt.conf         = byte_q;
                default:
                    vol_nxt.conf         = vol_r.conf;
            endcase
            if (vol_r.nbytes != lockdown_pkg::NBYTES_CONFIRM)
                vol_nxt.nbytes = byte_num + 3'h1;
        end

        // Lock timer: the bit lands when the timer runs out, within the lock time.
        if (vol_r.busy)
        begin
            if (vol_r.timer == 32'h0)
            begin
                vol_nxt.busy = 1'b0;
                if (vol_r.pend_freeze)
                begin
                    nv_nxt.frozen = 1'b1;
                    vol_nxt.lockdown_enable_bit   = 1'b0;
                end
                else
                begin
                    nv_nxt.lockdown[vol_r.pend_sector] = 1'b1;
                end
            end
            else
            begin
                vol_nxt.timer = vol_r.timer - 32'h1;
            end
        end

        // Commands take effect when chip select rises; none are taken while busy.
        if (frame_end)
        begin
            vol_nxt.nbytes = '0;
            if (!vol_r.busy && aligned && vol_r.nbytes >= lockdown_pkg::NBYTES_OPCODE)
            begin
                case (vol_r.opcode)
                    lockdown_pkg::OP_WRITE_ENABLE:
                        vol_nxt.write_enable_latch = 1'b1;
                    lockdown_pkg::OP_WRITE_DISABLE:
                        vol_nxt.write_enable_latch = 1'b0;
                    lockdown_pkg::OP_WRITE_STATUS1:
                    begin
                        if (vol_r.write_enable_latch && !hw_lock &&
                            vol_r.nbytes >= lockdown_pkg::NBYTES_STATUS)
                        begin
                            vol_nxt.write_enable_latch  = 1'b0;
                            vol_nxt.protection_regs_lock_bit = new_lock;
                            // Globals act only while unlocked beforehand.
                            if (!vol_r.protection_regs_lock_bit)
                            begin
                                if (global_code == lockdown_pkg::GLOBAL_UNPROTECT)
                                    vol_nxt.prot = '0;
                                else if (global_code == lockdown_pkg::GLOBAL_PROTECT)
                                    vol_nxt.prot = '1;
                            end
                        end
                    end
                    lockdown_pkg::OP_WRITE_STATUS2:
                    begin
                        if (vol_r.write_enable_latch && vol_r.nbytes >= lockdown_pkg::NBYTES_STATUS)
                        begin
                            vol_nxt.write_enable_latch = 1'b0;
                            if (!nv_r.frozen)
                                vol_nxt.lockdown_enable_bit = vol_r.data1[lockdown_pkg::LOCKEN_BIT_POS];
                        end
                    end
                    lockdown_pkg::OP_PROTECT_SECT,
                    lockdown_pkg::OP_UNPROTECT_SECT:
                    begin
                        if (vol_r.write_enable_latch)
                        begin
                            vol_nxt.write_enable_latch = 1'b0;
                            // Either lock freezes the per-sector protection bits.
                            if (!vol_r.protection_regs_lock_bit &&
                                vol_r.nbytes >= lockdown_pkg::NBYTES_ADDR)
                                vol_nxt.prot[sector] =
                                    (vol_r.opcode == lockdown_pkg::OP_PROTECT_SECT);
                        end
                    end
                    lockdown_pkg::OP_SECT_LOCKDOWN:
                    begin
                        if (vol_r.write_enable_latch)
                        begin
                            vol_nxt.write_enable_latch = 1'b0;
                            if (vol_r.lockdown_enable_bit && !nv_r.frozen &&
                                vol_r.nbytes >= lockdown_pkg::NBYTES_CONFIRM &&
                                vol_r.conf == lockdown_pkg::CONFIRM_BYTE)
                            begin
                                vol_nxt.busy        = 1'b1;
                                vol_nxt.pend_freeze = 1'b0;
                                vol_nxt.pend_sector = sector;
                                vol_nxt.timer       = 32'(LOCK_CYCLES - 1);
                            end
                        end
                    end
                    lockdown_pkg::OP_FREEZE_LOCK:
                    begin
                        if (vol_r.write_enable_latch && vol_r.lockdown_enable_bit)
                        begin
                            vol_nxt.write_enable_latch = 1'b0;
                            if (!nv_r.frozen &&
                                vol_r.nbytes >= lockdown_pkg::NBYTES_CONFIRM &&
                                vol_r.addr == lockdown_pkg::FREEZE_ADDR &&
                                vol_r.conf == lockdown_pkg::CONFIRM_BYTE)
                            begin
                                vol_nxt.busy        = 1'b1;
                                vol_nxt.pend_freeze = 1'b1;
                                vol_nxt.timer       = 32'(LOCK_CYCLES - 1);
                            end
                        end
                        else if (vol_r.write_enable_latch)
                        begin
                            vol_nxt.write_enable_latch = 1'b0;
                        end
                    end
                    default:
                        vol_nxt.opcode = vol_r.opcode;
                endcase
            end
            else if (!vol_r.busy && vol_r.nbytes != 3'h0 &&
                     (vol_r.opcode == lockdown_pkg::OP_SECT_LOCKDOWN ||
                      vol_r.opcode == lockdown_pkg::OP_FREEZE_LOCK))
            begin
                // A frame cut off a byte boundary aborts; only the latch drops.
                vol_nxt.write_enable_latch = 1'b0;
            end
        end

        // Frozen state pins the enable low for good.
        if (nv_r.frozen)
            vol_nxt.lockdown_enable_bit = 1'b0;
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    // Power-up: every sector protected, no lock, latch clear.
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            vol_r <= '{prot: '1, default: '0};
        else
            vol_r <= vol_nxt;
    end

    // A plain reset does not touch the lockdown bits; only factory init does.
    always_ff @(posedge clk_i or negedge nv_init_n_i)
    begin
        if (!nv_init_n_i)
            nv_r <= '0;
        else
            nv_r <= nv_nxt;
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign write_enable_latch_o       = vol_r.write_enable_latch;
    assign protection_regs_lock_bit_o = vol_r.protection_regs_lock_bit;
    assign lockdown_enable_bit_o      = vol_r.lockdown_enable_bit;
    assign hw_locked_o                = vol_r.hw_locked;
    assign frozen_o                   = nv_r.frozen;
    assign busy_o                     = vol_r.busy;
    assign sect_protect_o             = vol_r.prot;
    assign sect_lockdown_o            = nv_r.lockdown;

endmodule : sector_lock_protection

// ---- hdl/spi_frame_rx.sv ----
// Serial link sampler: synchronises the pins and assembles command bytes.
`timescale 1ns/100ps

module spi_frame_rx
(
    input  wire logic       clk_i,       // System clock.
    input  wire logic       resetn_i,    // Asynchronous reset, active low.
    input  wire logic       sck_i,       // Serial clock pin.
    input  wire logic       cs_n_i,      // Chip select pin, active low.
    input  wire logic       si_i,        // Serial data in pin.
    input  wire logic       wp_n_i,      // Write protect pin, active low.
    output logic            byte_vld_o,  // Pulse: a whole byte arrived.
    output logic [7:0]      byte_o,      // The byte just received.
    output logic [2:0]      byte_num_o,  // Position of that byte in the frame.
    output logic            frame_end_o, // Pulse: chip select rose.
    output logic            aligned_o,   // Frame ended on a byte boundary.
    output logic            wp_n_o       // Synchronised write protect level.
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [3:0] sync1;
        logic [3:0] sync2;
        logic       sck_d;
        logic       cs_d;
        logic [6:0] shift;
        logic [2:0] bit_cnt;
        logic [2:0] nbyte;
        logic       byte_vld;
        logic [7:0] byte_q;
        logic [2:0] byte_num;
        logic       frame_end;
        logic       aligned;
    } rx_t;

    rx_t rx_r;
    rx_t rx_nxt;

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb
    begin
        rx_nxt           = rx_r;
        rx_nxt.sync1     = {wp_n_i, si_i, cs_n_i, sck_i};
        rx_nxt.sync2     = rx_r.sync1;
        rx_nxt.sck_d     = rx_r.sync2[0];
        rx_nxt.cs_d      = rx_r.sync2[1];
        rx_nxt.byte_vld  = 1'b0;
        rx_nxt.frame_end = 1'b0;
        if (rx_r.cs_d && !rx_r.sync2[1])
        begin
            rx_nxt.bit_cnt = '0;
            rx_nxt.nbyte   = '0;
        end
        else if (!rx_r.sync2[1] && rx_r.sync2[0] && !rx_r.sck_d)
        begin
            rx_nxt.shift = {rx_r.shift[5:0], rx_r.sync2[2]};
            if (rx_r.bit_cnt == lockdown_pkg::BIT_LAST)
            begin
                rx_nxt.bit_cnt  = '0;
                rx_nxt.byte_vld = 1'b1;
                rx_nxt.byte_q   = {rx_r.shift, rx_r.sync2[2]};
                rx_nxt.byte_num = rx_r.nbyte;
                if (rx_r.nbyte != lockdown_pkg::BIT_LAST)
                    rx_nxt.nbyte = rx_r.nbyte + 3'h1;
            end
            else
            begin
                rx_nxt.bit_cnt = rx_r.bit_cnt + 3'h1;
            end
        end
        if (!rx_r.cs_d && rx_r.sync2[1])
        begin
            rx_nxt.frame_end = 1'b1;
            rx_nxt.aligned   = (rx_r.bit_cnt == 3'h0);
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            rx_r <= '{sync1: 4'hf, sync2: 4'hf, sck_d: 1'b1, cs_d: 1'b1, default: '0};
        else
            rx_r <= rx_nxt;
    end

    assign byte_vld_o  = rx_r.byte_vld;
    assign byte_o      = rx_r.byte_q;
    assign byte_num_o  = rx_r.byte_num;
    assign frame_end_o = rx_r.frame_end;
    assign aligned_o   = rx_r.aligned;
    assign wp_n_o      = rx_r.sync2[3];

endmodule : spi_frame_rx

// ---- test/sector_lock_protection_chk.sv ----
// Port level checks for the sector protection and lockdown block.
`timescale 1ns/100ps

module sector_lock_protection_chk
#(
    parameter int NUM_SECTORS = 64,
    parameter int LOCK_CYCLES = 8
)
(
    input wire logic                   clk_i,                      // Clock.
    input wire logic                   resetn_i,                   // Reset.
    input wire logic                   nv_init_n_i,                // Factory init.
    input wire logic                   sck_i,                      // Serial clock.
    input wire logic                   cs_n_i,                     // Chip select.
    input wire logic                   si_i,                       // Serial data.
    input wire logic                   wp_n_i,                     // Write protect.
    input wire logic                   write_enable_latch_o,       // Write enable.
    input wire logic                   protection_regs_lock_bit_o, // Lock bit.
    input wire logic                   lockdown_enable_bit_o,      // Lockdown enable.
    input wire logic                   hw_locked_o,                // Hardware lock.
    input wire logic                   frozen_o,                   // Frozen.
    input wire logic                   busy_o,                     // Timer running.
    input wire logic [NUM_SECTORS-1:0] sect_protect_o,             // Protection bits.
    input wire logic [NUM_SECTORS-1:0] sect_lockdown_o             // Lockdown bits.
);
    localparam int LO = LOCK_CYCLES;
    localparam int HI = LOCK_CYCLES + 2;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i || !nv_init_n_i);

    sequence s_start; $rose(busy_o); endsequence
    sequence s_done; !write_enable_latch_o ##[LO:HI] $fell(busy_o); endsequence

    property p_hw; wp_n_i == $past(wp_n_i, 6) && $stable(protection_regs_lock_bit_o)
        |=> hw_locked_o == (!$past(wp_n_i) && $past(protection_regs_lock_bit_o)); endproperty
    a_hw: assert property (p_hw) else $error("hardware lock level wrong");
    property p_hw_hold; hw_locked_o |=> $stable({protection_regs_lock_bit_o, sect_protect_o});
    endproperty
    a_hw_hold: assert property (p_hw_hold) else $error("locked state changed");
    property p_sw_hold; $past(protection_regs_lock_bit_o) |-> $stable(sect_protect_o); endproperty
    a_sw_hold: assert property (p_sw_hold) else $error("protection changed");
    property p_ld_keep; ($past(sect_lockdown_o) & ~sect_lockdown_o) == '0; endproperty
    a_ld_keep: assert property (p_ld_keep) else $error("lockdown bit cleared");
    property p_ld_time; sect_lockdown_o != $past(sect_lockdown_o) |-> $fell(busy_o); endproperty
    a_ld_time: assert property (p_ld_time) else $error("lockdown set off timer");
    property p_busy; s_start |-> s_done; endproperty
    a_busy: assert property (p_busy) else $error("lock timer length wrong");
    property p_frz_keep; frozen_o |=> frozen_o && $stable(sect_lockdown_o); endproperty
    a_frz_keep: assert property (p_frz_keep) else $error("frozen state changed");
    property p_frz_sle; frozen_o |-> !lockdown_enable_bit_o; endproperty
    a_frz_sle: assert property (p_frz_sle) else $error("enable set while frozen");
    property p_frz_rise; $rose(frozen_o) |-> $fell(busy_o); endproperty
    a_frz_rise: assert property (p_frz_rise) else $error("freeze off timer");
    property p_frame; $changed({write_enable_latch_o, protection_regs_lock_bit_o,
        sect_protect_o}) |-> cs_n_i; endproperty
    a_frame: assert property (p_frame) else $error("state changed inside frame");
endmodule : sector_lock_protection_chk

bind sector_lock_protection sector_lock_protection_chk #(.NUM_SECTORS(NUM_SECTORS),
    .LOCK_CYCLES(LOCK_CYCLES)) i_chk (.*);

// ---- test/spi_host_model.sv ----
// Behavioural serial host that sends command frames to the device.
`timescale 1ns/100ps

module spi_host_model
(
    output logic sck_o,  // Serial clock, low between frames.
    output logic cs_n_o, // Chip select, active low.
    output logic si_o    // Serial data to the device.
);
    initial
    begin
        sck_o = 1'b0;
        cs_n_o = 1'b1;
        si_o = 1'b1;
    end

    // Sends the top n bits of d, MSB first, 160 ns per bit.
    task automatic frame(input logic [39:0] d, input int n);
        cs_n_o = 1'b0;
        for (int i = 0; i < n; i++)
        begin
            si_o = d[39-i];
            #80 sck_o = 1'b1;
            #80 sck_o = 1'b0;
        end
        #80 cs_n_o = 1'b1;
        // A released data line must not keep showing its last bit.
        si_o = ~si_o;
        #400;
    endtask : frame
endmodule : spi_host_model

// ---- test/testbench.sv ----
// Self-checking bench for the sector protection and lockdown block.
`timescale 1ns/100ps

module testbench;
    logic        clk_i       = 1'b0;
    logic        resetn_i    = 1'b0;
    logic        nv_init_n_i = 1'b0;
    logic        wp_n_i      = 1'b1;
    logic        sck, cs_n, si, write_enable_latch, lock, lockdown_enable_bit, hwl, frz, busy;
    logic [63:0] prot, ld;
    logic [55:0] rows [0:19];
    int          fail_count  = 0;
    int          n_tests     = 0;
    wire  [7:0]  st = {write_enable_latch, lock, lockdown_enable_bit, frz, hwl, prot[0], ld[3], ld[5]};

    always #10 clk_i = ~clk_i;

    spi_host_model i_spi_host_model (.sck_o(sck), .cs_n_o(cs_n), .si_o(si));
    sector_lock_protection #(.LOCK_CYCLES(8)) i_sector_lock_protection (.clk_i(clk_i),
        .resetn_i(resetn_i), .nv_init_n_i(nv_init_n_i), .sck_i(sck), .cs_n_i(cs_n),
        .si_i(si), .wp_n_i(wp_n_i), .write_enable_latch_o(write_enable_latch), .hw_locked_o(hwl),
        .protection_regs_lock_bit_o(lock), .lockdown_enable_bit_o(lockdown_enable_bit), .frozen_o(frz),
        .busy_o(busy), .sect_protect_o(prot), .sect_lockdown_o(ld));

    task automatic wrap_up();
        if (fail_count == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : wrap_up

    task automatic chk(input logic [7:0] exp);
        n_tests++;
        if (st !== exp)
        begin
            fail_count++;
            $display("Error status: expected %h, seen %h", exp, st);
        end
    endtask : chk

    // Data is right aligned; the lock timer is waited out with a bound.
    task automatic send(input logic [39:0] d, input logic [5:0] n);
        int k = 0;
        i_spi_host_model.frame(d << (40 - n), n);
        while (busy !== 1'b0 && k < 100)
        begin
            @(negedge clk_i);
            k++;
        end
    endtask : send

    initial
    begin
        #1000000;
        fail_count++;
        wrap_up();
    end

    initial
    begin
        rows = '{{2'b11, 40'h0100, 6'd16, 8'h00},
                 {2'b11, 40'h017f, 6'd16, 8'h04},
                 {2'b11, 40'h0180, 6'd16, 8'h40},
                 {2'b11, 40'h36000000, 6'd32, 8'h40},
                 {2'b10, 40'h0100, 6'd16, 8'hc8},
                 {2'b01, 40'h013c, 6'd16, 8'h00},
                 {2'b11, 40'h36000000, 6'd32, 8'h04},
                 {2'b11, 40'h39000000, 6'd32, 8'h00},
                 {2'b11, 40'h04, 6'd8, 8'h00},
                 {2'b11, 40'h33050000d0, 6'd40, 8'h00},
                 {2'b11, 40'h3110, 6'd16, 8'h20},
                 {2'b11, 40'h33030000d0, 6'd40, 8'h22},
                 {2'b11, 40'h33050000d1, 6'd40, 8'h22},
                 {2'b11, 40'h1982800068, 6'd39, 8'h22},
                 {2'b11, 40'h330500, 6'd24, 8'h22},
                 {2'b11, 40'h3455aa41d0, 6'd40, 8'h22},
                 {2'b11, 40'h3455aa40d0, 6'd40, 8'h12},
                 {2'b11, 40'h33050000d0, 6'd40, 8'h12},
                 {2'b10, 40'h0180, 6'd16, 8'h5a},
                 {2'b10, 40'h0100, 6'd16, 8'hda}};
        repeat (12) @(negedge clk_i);
        resetn_i = 1'b1;
        nv_init_n_i = 1'b1;
        repeat (4) @(negedge clk_i);
        chk(8'h04);
        foreach (rows[r])
        begin
            @(negedge clk_i);
            wp_n_i = rows[r][54];
            if (rows[r][55])
                send(40'h06, 6'd8);
            send(rows[r][53:14], rows[r][13:8]);
            chk(rows[r][7:0]);
        end
        @(negedge clk_i);
        resetn_i = 1'b0;
        repeat (2) @(negedge clk_i);
        resetn_i = 1'b1;
        repeat (4) @(negedge clk_i);
        chk(8'h16);
        wrap_up();
    end
endmodule : testbench
